// >>> twem_master.sv
// twem_master: two-wire serial eeprom master with config registers and boot download
// assumes pins and reset terminals are asynchronous; cfg port is on CLOCK
// Functional notes
// - on the later reset release, sample clock pin pullup into present bit 3
// - writing zero to present bit disables the interface immediately
// - interface enabled takes shared pins from gpio; disabled returns them
// - clock line output only, data bidirectional, both open-drain
// - clock toggles near 60 kHz in transfers, released when idle
// - start is data falling with clock high, stop data rising
// - data changes only while clock low, except start and stop
// - eight-bit bytes each followed by an ack held low through clock high
// - single bytes on software request; multibyte download right after reset
// - write: start, address+0, ack, word, ack, data msb first, ack, stop
// - missing address acknowledge sets error bit 1
// - read: address+0, word, repeated start, address+1, data, no-ack, stop
// - download reads like byte read, acking each byte until the last
// - protocol-select bit 7 drops the word address byte and its ack
// - download-active bit 4 held during download; failure in bit 0
// - download uses fixed eeprom slave address 1010000b
// - writing the slave-address register launches a single-byte transaction
`timescale 1ns/1ps
`default_nettype none
module twem_master
    import twem_pkg::*;
#(
    parameter int QTR_CYC = QTR_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic FUNDAMENTAL_RESET_IN_N,
    input wire logic GLOBAL_RESET_IN_N,
    input wire twem_cfg_req_t CFG_REQ,
    output logic [7:0] CFG_RDATA,
    input wire logic SHARED_PIN_A_I,
    output logic SHARED_PIN_A_O,
    output logic SHARED_PIN_A_OE,
    input wire logic SHARED_PIN_B_I,
    output logic SHARED_PIN_B_O,
    output logic SHARED_PIN_B_OE,
    input wire logic GPIO_A_DO,
    input wire logic GPIO_A_OE,
    output logic GPIO_A_DI,
    input wire logic GPIO_B_DO,
    input wire logic GPIO_B_OE,
    output logic GPIO_B_DI,
    output logic DL_VALID,
    output twem_dl_word_t DL_WORD,
    input wire logic DL_READY
);
    twem_core_t r;
    twem_core_t n;
    logic buf_ready;
    logic tick;
    logic stall;
    logic rst_rise;
    logic launch;
    logic go;
    logic go_rd;
    logic [6:0] go_slave;
    logic nack_evt;
    logic more;
    logic sda_in;
    logic tx_byte;

    twem_pair_buf #(
        .WIDTH($bits(twem_dl_word_t))
    ) u_dl_buf (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .IN_VALID(r.push_v),
        .IN_READY(buf_ready),
        .IN_DATA(r.push_d),
        .OUT_VALID(DL_VALID),
        .OUT_READY(DL_READY),
        .OUT_DATA(DL_WORD)
    );

    always_comb begin
        n = r;
        go = 1'b0;
        go_rd = 1'b0;
        go_slave = EEPROM_ADDR;
        launch = 1'b0;
        nack_evt = 1'b0;
        more = 1'b0;
        stall = 1'b0;
        sda_in = r.pa_sync[1];
        tx_byte = (r.phase != PH_DATAR);
        // synchronisers
        n.rst_a_sync = {r.rst_a_sync[0], FUNDAMENTAL_RESET_IN_N};
        n.rst_b_sync = {r.rst_b_sync[0], GLOBAL_RESET_IN_N};
        n.pa_sync = {r.pa_sync[0], SHARED_PIN_A_I};
        n.pb_sync = {r.pb_sync[0], SHARED_PIN_B_I};
        n.both_prev = r.rst_a_sync[1] && r.rst_b_sync[1];
        rst_rise = n.both_prev && !r.both_prev;
        if (r.push_v && buf_ready) begin
            n.push_v = 1'b0;
        end
        // configuration writes
        if (CFG_REQ.wr) begin
            unique case (CFG_REQ.addr)
                REG_DATA_OFF: n.data = CFG_REQ.wdata;
                REG_WORD_OFF: n.word = CFG_REQ.wdata;
                REG_SLAVE_OFF: begin
                    n.slave = CFG_REQ.wdata;
                    if (r.present && r.state == ST_IDLE && !r.dl_active) begin
                        launch = 1'b1;
                        go = 1'b1;
                        go_rd = CFG_REQ.wdata[0];
                        go_slave = CFG_REQ.wdata[7:1];
                    end
                end
                REG_CTRL_OFF: begin
                    n.prot_sel = CFG_REQ.wdata[CS_PROT_SEL];
                    if (!CFG_REQ.wdata[CS_PRESENT]) begin
                        n.present = 1'b0;
                    end
                    if (CFG_REQ.wdata[CS_NO_ACK]) begin
                        n.no_ack_err = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // pullup detect at the later reset release
        if (rst_rise) begin
            n.present = r.pb_sync[1];
            if (r.pb_sync[1]) begin
                go = 1'b1;
                go_rd = 1'b1;
                go_slave = EEPROM_ADDR;
                n.is_dl = 1'b1;
                n.dl_active = 1'b1;
                n.dl_err = 1'b0;
                n.dl_idx = 8'h00;
            end
        end
        if (go) begin
            n.state = ST_START;
            n.is_read = go_rd;
            n.is_dl = rst_rise;
            n.qtr = 2'h0;
            n.div = 16'h0000;
            n.fail = 1'b0;
            n.phase = (go_rd && r.prot_sel) ? PH_DEVR : PH_DEVW;
            n.shift = {go_slave, go_rd && r.prot_sel};
        end
        // quarter-bit divider
        tick = (r.div == 16'(QTR_CYC - 1));
        if (r.state != ST_IDLE && !go) begin
            n.div = tick ? 16'h0000 : 16'(r.div + 16'h0001);
        end
        if (r.state == ST_XFER && r.phase == PH_DATAR && r.bit_cnt == ACK_BIT && r.qtr == 2'h0) begin
            stall = r.is_dl && r.push_v; // back-pressure from download stream
        end
        if (tick && !stall && r.state != ST_IDLE && !go) begin
            n.qtr = 2'(r.qtr + 2'h1);
            unique case (r.state)
                ST_START: begin
                    unique case (r.qtr)
                        2'h0: n.sda_low = 1'b0;
                        2'h1: n.scl_low = 1'b0;
                        2'h2: n.sda_low = 1'b1;
                        default: begin
                            n.scl_low = 1'b1;
                            n.state = ST_XFER;
                            n.bit_cnt = 4'h0;
                        end
                    endcase
                end
                ST_XFER: begin
                    unique case (r.qtr)
                        2'h0: begin
                            if (r.bit_cnt != ACK_BIT) begin
                                n.sda_low = tx_byte && !r.shift[7];
                            end else if (tx_byte) begin
                                n.sda_low = 1'b0;
                            end else begin
                                if (r.is_dl) begin
                                    if (r.dl_idx == 8'h00) begin
                                        more = (r.shift == DL_FUNC_ID);
                                        n.fail = r.shift != DL_FUNC_ID;
                                    end else if (r.dl_idx == 8'h01) begin
                                        more = 1'b1;
                                        n.dl_cnt = r.shift;
                                    end else begin
                                        more = (r.dl_idx != 8'(r.dl_cnt + DL_HDR_BYTES));
                                        if (!more && r.shift != DL_END_MARK) begin
                                            n.fail = 1'b1;
                                        end
                                    end
                                    n.push_v = 1'b1;
                                    n.push_d = '{index: r.dl_idx, data: r.shift};
                                    n.dl_idx = 8'(r.dl_idx + 8'h01);
                                end else begin
                                    n.data = r.shift;
                                end
                                n.sda_low = more;
                                n.last = !more;
                            end
                        end
                        2'h1: n.scl_low = 1'b0;
                        2'h2: begin
                            if (r.bit_cnt != ACK_BIT) begin
                                n.shift = {r.shift[6:0], sda_in};
                            end else begin
                                n.acked = !sda_in;
                            end
                        end
                        default: begin
                            n.scl_low = 1'b1;
                            n.bit_cnt = 4'(r.bit_cnt + 4'h1);
                            if (r.bit_cnt == ACK_BIT) begin
                                n.bit_cnt = 4'h0;
                                if (tx_byte && !r.acked) begin
                                    nack_evt = 1'b1;
                                    n.no_ack_err = 1'b1;
                                    n.fail = 1'b1;
                                    n.state = ST_STOP;
                                end else begin
                                    unique case (r.phase)
                                        PH_DEVW: begin
                                            n.phase = r.prot_sel ? PH_DATAW : PH_WORD;
                                            n.shift = r.prot_sel ? r.data : (r.is_dl ? DL_WORD_ADDR : r.word);
                                        end
                                        PH_WORD: begin
                                            if (r.is_read) begin
                                                n.state = ST_START;
                                                n.phase = PH_DEVR;
                                                n.shift = {(r.is_dl ? EEPROM_ADDR : r.slave[7:1]), 1'b1};
                                            end else begin
                                                n.phase = PH_DATAW;
                                                n.shift = r.data;
                                            end
                                        end
                                        PH_DATAW: n.state = ST_STOP;
                                        PH_DEVR: n.phase = PH_DATAR;
                                        default: n.state = r.last ? ST_STOP : ST_XFER;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                default: begin
                    unique case (r.qtr)
                        2'h0: n.sda_low = 1'b1;
                        2'h1: n.scl_low = 1'b0;
                        2'h2: n.sda_low = 1'b0;
                        default: begin
                            n.state = ST_IDLE;
                            if (r.is_dl) begin
                                n.dl_active = 1'b0;
                                n.dl_err = r.fail;
                            end
                        end
                    endcase
                end
            endcase
        end
        // disable wins over any transfer in flight
        if (!n.present) begin
            n.state = ST_IDLE;
            n.scl_low = 1'b0;
            n.sda_low = 1'b0;
            n.dl_active = 1'b0;
        end
        if (n.state == ST_IDLE) begin
            n.scl_low = 1'b0;
            n.sda_low = 1'b0;
            n.div = 16'h0000;
            n.qtr = 2'h0;
        end
        // shared pin steering, open-drain when enabled
        n.pa_o = n.present ? 1'b0 : GPIO_A_DO;
        n.pa_oe = n.present ? n.sda_low : GPIO_A_OE;
        n.pb_o = n.present ? 1'b0 : GPIO_B_DO;
        n.pb_oe = n.present ? n.scl_low : GPIO_B_OE;
        n.gpa_di = n.present ? 1'b0 : r.pa_sync[1];
        n.gpb_di = n.present ? 1'b0 : r.pb_sync[1];
        if (CFG_REQ.rd) begin
            unique case (CFG_REQ.addr)
                REG_DATA_OFF: n.rdata = r.data;
                REG_WORD_OFF: n.rdata = r.word;
                REG_SLAVE_OFF: n.rdata = r.slave;
                REG_CTRL_OFF: n.rdata = {r.prot_sel, 1'b0, (r.state != ST_IDLE) && !r.dl_active,
                                         r.dl_active, r.present, 1'b0, r.no_ack_err, r.dl_err};
                default: n.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            r <= '0;
            r.state <= ST_IDLE;
            r.phase <= PH_DEVW;
            r.data <= REG_RESET;
            r.word <= REG_RESET;
            r.slave <= REG_RESET;
        end else begin
            r <= n;
        end
    end

    assign CFG_RDATA = r.rdata;
    assign SHARED_PIN_A_O = r.pa_o;
    assign SHARED_PIN_A_OE = r.pa_oe;
    assign SHARED_PIN_B_O = r.pb_o;
    assign SHARED_PIN_B_OE = r.pb_oe;
    assign GPIO_A_DI = r.gpa_di;
    assign GPIO_B_DI = r.gpb_di;

    a_present_sample: assert property (@(posedge CLOCK) disable iff (RESET)
        rst_rise |=> (r.present == $past(r.pb_sync[1]))) else $error("present bit not sampled");
    a_disable_write: assert property (@(posedge CLOCK) disable iff (RESET)
        (CFG_REQ.wr && CFG_REQ.addr == REG_CTRL_OFF && !CFG_REQ.wdata[CS_PRESENT])
        |=> (!r.present && r.state == ST_IDLE)) else $error("disable write ignored");
    a_gpio_blocked: assert property (@(posedge CLOCK) disable iff (RESET)
        r.present |-> (!r.gpa_di && !r.gpb_di)) else $error("gpio input seen while enabled");
    a_open_drain: assert property (@(posedge CLOCK) disable iff (RESET)
        r.present |-> (!r.pa_o && !r.pb_o)) else $error("pin driven high");
    a_scl_idle_free: assert property (@(posedge CLOCK) disable iff (RESET)
        (r.present && r.state == ST_IDLE) |-> !r.pb_oe) else $error("clock held while idle");
    a_sda_stable_high: assert property (@(posedge CLOCK) disable iff (RESET)
        (r.state == ST_XFER && $past(r.state) == ST_XFER && !r.scl_low && !$past(r.scl_low))
        |-> $stable(r.sda_low)) else $error("data moved with clock high");
    a_nack_flag: assert property (@(posedge CLOCK) disable iff (RESET)
        (nack_evt && (r.phase == PH_DEVW || r.phase == PH_DEVR)) |=> (r.no_ack_err && r.state == ST_STOP))
        else $error("missing ack not flagged");
    a_launch_start: assert property (@(posedge CLOCK) disable iff (RESET)
        launch |=> (r.state == ST_START && r.qtr == 2'h0)) else $error("slave write did not launch");
    a_write_first: assert property (@(posedge CLOCK) disable iff (RESET)
        (launch && !CFG_REQ.wdata[0]) |=> (r.phase == PH_DEVW && !r.shift[0])) else $error("bad write header");
    a_dl_boot: assert property (@(posedge CLOCK) disable iff (RESET)
        (rst_rise && r.pb_sync[1]) |=> (r.dl_active && r.is_dl && r.state == ST_START))
        else $error("download not started");
    a_dl_active_end: assert property (@(posedge CLOCK) disable iff (RESET)
        $fell(r.dl_active) |-> (r.state == ST_IDLE)) else $error("download flag dropped early");
endmodule // twem_master
`default_nettype wire

// >>> twem_pkg.sv
// twem_pkg: constants, encodings and carrier types of the two-wire eeprom master
// assumes a 100 MHz core clock and byte-wide configuration-space access
package twem_pkg;

    // configuration-space byte offsets
    localparam logic [7:0] REG_DATA_OFF = 8'hB0;
    localparam logic [7:0] REG_WORD_OFF = 8'hB1;
    localparam logic [7:0] REG_SLAVE_OFF = 8'hB2;
    localparam logic [7:0] REG_CTRL_OFF = 8'hB3;

    // control/status field positions
    localparam int CS_PROT_SEL = 7;
    localparam int CS_REQ_BUSY = 5;
    localparam int CS_DL_ACTIVE = 4;
    localparam int CS_PRESENT = 3;
    localparam int CS_NO_ACK = 1;
    localparam int CS_DL_ERR = 0;

    // bus and download constants
    localparam logic [6:0] EEPROM_ADDR = 7'h50;
    localparam logic [7:0] DL_WORD_ADDR = 8'h00;
    localparam logic [7:0] DL_FUNC_ID = 8'h00;
    localparam logic [7:0] DL_END_MARK = 8'h80;
    localparam logic [7:0] DL_HDR_BYTES = 8'h02;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [7:0] REG_RESET = 8'h00;

    // serial clock timing
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int SCL_FREQ_HZ = 60_000;
    localparam int QTR_CYCLES = CLK_FREQ_HZ / (4 * SCL_FREQ_HZ);

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_START = 4'h2,
        ST_XFER = 4'h4,
        ST_STOP = 4'h8
    } twem_state_t;

    typedef enum logic [4:0] {
        PH_DEVW = 5'h01,
        PH_WORD = 5'h02,
        PH_DATAW = 5'h04,
        PH_DEVR = 5'h08,
        PH_DATAR = 5'h10
    } twem_phase_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } twem_cfg_req_t;

    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } twem_dl_word_t;

    typedef struct packed {
        twem_state_t state;
        twem_phase_t phase;
        logic [1:0] qtr;
        logic [15:0] div;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic acked;
        logic last;
        logic scl_low;
        logic sda_low;
        logic is_read;
        logic is_dl;
        logic fail;
        logic [7:0] dl_idx;
        logic [7:0] dl_cnt;
        logic [7:0] data;
        logic [7:0] word;
        logic [7:0] slave;
        logic prot_sel;
        logic present;
        logic no_ack_err;
        logic dl_err;
        logic dl_active;
        logic [1:0] rst_a_sync;
        logic [1:0] rst_b_sync;
        logic [1:0] pa_sync;
        logic [1:0] pb_sync;
        logic both_prev;
        logic pa_o;
        logic pa_oe;
        logic pb_o;
        logic pb_oe;
        logic gpa_di;
        logic gpb_di;
        logic [7:0] rdata;
        logic push_v;
        twem_dl_word_t push_d;
    } twem_core_t;

endpackage

// >>> twem_pair_buf.sv
// twem_pair_buf: two-entry buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module twem_pair_buf #(
    parameter int WIDTH = 16
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    typedef struct packed {
        logic v0;
        logic [WIDTH-1:0] d0;
        logic v1;
        logic [WIDTH-1:0] d1;
    } twem_buf_t;

    twem_buf_t buf_r;
    twem_buf_t buf_nxt;

    always_comb begin
        buf_nxt = buf_r;
        // head leaves, second entry moves up
        if (buf_r.v0 && OUT_READY) begin
            buf_nxt.v0 = buf_r.v1;
            buf_nxt.d0 = buf_r.d1;
            buf_nxt.v1 = 1'b0;
        end
        if (IN_VALID && !buf_r.v1) begin
            if (!buf_nxt.v0) begin
                buf_nxt.v0 = 1'b1;
                buf_nxt.d0 = IN_DATA;
            end else begin
                buf_nxt.v1 = 1'b1;
                buf_nxt.d1 = IN_DATA;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            buf_r <= '0;
        end else begin
            buf_r <= buf_nxt;
        end
    end

    assign IN_READY = !buf_r.v1;
    assign OUT_VALID = buf_r.v0;
    assign OUT_DATA = buf_r.d0;
endmodule // twem_pair_buf
`default_nettype wire

// >>> twem_eeprom_model.sv
// twem_eeprom_model: behavioural serial eeprom slave at address 50h
// assumes resolved open-drain line levels with pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module twem_eeprom_model (
    input wire logic scl,
    input wire logic sda,
    output logic sda_low
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rd;
    logic mack;
    int cnt;
    int ph;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'hA5 ^ i[7:0];
        mem[0] = 8'h00;
        mem[1] = 8'h03;
        mem[5] = 8'h80;
        sda_low = 1'b0;
        cnt = 0;
        ph = 3;
        rd = 1'b0;
        ptr = 8'h00;
    end
    // start condition restarts byte framing
    always @(negedge sda) begin
        if (scl) begin
            cnt = 0;
            ph = 0;
            rd = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else mack = !sda;
        cnt = cnt + 1;
    end
    // line changes only after the clock falls
    always @(negedge scl) begin
        sda_low = 1'b0;
        if (cnt == 8 && !rd) begin
            if (ph == 0 && sh[7:1] == 7'h50) begin
                sda_low = 1'b1;
                rd = sh[0];
                ph = 1;
            end else if (ph == 1) begin
                ptr = sh;
                sda_low = 1'b1;
                ph = 2;
            end else if (ph == 2) begin
                mem[ptr] = sh;
                sda_low = 1'b1;
            end else ph = 3;
        end
        if (cnt == 9) begin
            cnt = 0;
            if (rd && (ph == 1 || mack)) begin
                if (ph == 4) ptr = ptr + 8'h01;
                ph = 4;
                sh = mem[ptr];
            end else if (rd) ph = 3;
        end
        // sh shifts in the line on each of the eight data rising clocks, so bit 7 is always the next to send
        if (rd && ph == 4 && cnt < 8) sda_low = !sh[7];
    end
endmodule // twem_eeprom_model
`default_nettype wire

// >>> twem_master_bench.sv
// twem_master_bench: config-port tests of the two-wire eeprom master
// assumes the eeprom model on the far side and pull-ups on both lines
`timescale 1ns/1ps
`default_nettype none
module twem_master_bench;
    import twem_pkg::*;
    logic clock, reset, fund_n, glob_n, pull_b, sda_low, gpa_do, gpa_oe, dl_ready;
    logic pa_o, pa_oe, pb_o, pb_oe, gpa_di, gpb_di, dl_valid;
    logic [7:0] rdata;
    logic [7:0] v;
    twem_cfg_req_t req;
    twem_dl_word_t dl_word;
    int error_cnt, total_checks, tick, dl_n, n_rise, n_hi;
    wire scl = pb_oe ? pb_o : pull_b;
    wire sda = (pa_oe ? pa_o : 1'b1) & !sda_low;
    twem_master #(.QTR_CYC(4)) DUT (
        .CLOCK(clock), .RESET(reset), .FUNDAMENTAL_RESET_IN_N(fund_n), .GLOBAL_RESET_IN_N(glob_n),
        .CFG_REQ(req), .CFG_RDATA(rdata), .SHARED_PIN_A_I(sda), .SHARED_PIN_A_O(pa_o),
        .SHARED_PIN_A_OE(pa_oe), .SHARED_PIN_B_I(scl), .SHARED_PIN_B_O(pb_o), .SHARED_PIN_B_OE(pb_oe),
        .GPIO_A_DO(gpa_do), .GPIO_A_OE(gpa_oe), .GPIO_A_DI(gpa_di), .GPIO_B_DO(1'b0),
        .GPIO_B_OE(1'b0), .GPIO_B_DI(gpb_di), .DL_VALID(dl_valid), .DL_WORD(dl_word),
        .DL_READY(dl_ready)
    );
    twem_eeprom_model PARTNER (.scl(scl), .sda(sda), .sda_low(sda_low));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock) req <= '{1'b1, 1'b0, a, d};
        @(posedge clock) req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock) req <= '0;
        #1 d = rdata;
    endtask
    task automatic idle();
        v = 8'hFF;
        for (int i = 0; i < 2000 && v[5:4] != 2'b00; i++) rd(REG_CTRL_OFF, v);
        chk({7'h00, pb_oe}, 8'h00);
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge scl) n_rise++;
    always @(sda) if (scl) n_hi++;
    // download consumer, stalls half the time
    always @(posedge clock) begin
        tick <= tick + 1;
        dl_ready <= tick[4];
        if (dl_valid && dl_ready) begin
            chk(dl_word.index, dl_n[7:0]);
            chk(dl_word.data, PARTNER.mem[dl_n]);
            dl_n <= dl_n + 1;
        end
        if (tick == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        reset = 1'b1;
        fund_n = 1'b0;
        glob_n = 1'b1;
        pull_b = 1'b1;
        req = '0;
        gpa_do = 1'b0;
        gpa_oe = 1'b0;
        dl_ready = 1'b0;
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1 chk({5'h00, pa_oe, pb_oe, dl_valid}, 8'h00);
        @(posedge clock) fund_n <= 1'b1;
        repeat (12) @(posedge clock);
        rd(REG_CTRL_OFF, v);
        chk(v, 8'h18);
        idle();
        chk(v, 8'h08);
        repeat (40) @(posedge clock);
        chk(dl_n[7:0], 8'h06);
        rd(8'h40, v);
        chk(v, 8'h00);
        wr(REG_WORD_OFF, 8'h10);
        wr(REG_DATA_OFF, 8'h3C);
        n_rise = 0;
        n_hi = 0;
        wr(REG_SLAVE_OFF, 8'hA0);
        idle();
        chk(PARTNER.mem[16], 8'h3C);
        chk(n_rise[7:0], 8'h1C);
        chk(n_hi[7:0], 8'h02);
        wr(REG_DATA_OFF, 8'h00);
        wr(REG_SLAVE_OFF, 8'hA1);
        idle();
        rd(REG_DATA_OFF, v);
        chk(v, 8'h3C);
        wr(REG_CTRL_OFF, 8'h88);
        wr(REG_WORD_OFF, 8'h05);
        wr(REG_DATA_OFF, 8'h00);
        wr(REG_SLAVE_OFF, 8'hA1);
        idle();
        rd(REG_DATA_OFF, v);
        chk(v, 8'h3C);
        wr(REG_CTRL_OFF, 8'h08);
        wr(REG_SLAVE_OFF, 8'hA4);
        idle();
        chk(v, 8'h0A);
        wr(REG_CTRL_OFF, 8'h0A);
        rd(REG_CTRL_OFF, v);
        chk(v, 8'h08);
        wr(REG_CTRL_OFF, 8'h00);
        gpa_oe <= 1'b1;
        wr(REG_SLAVE_OFF, 8'hA0);
        repeat (6) @(posedge clock);
        rd(REG_CTRL_OFF, v);
        chk(v, 8'h00);
        chk({6'h00, pa_oe, pa_o}, 8'h02);
        chk({7'h00, gpb_di}, 8'h01);
        @(posedge clock) gpa_oe <= 1'b0;
        repeat (4) @(posedge clock);
        #1 chk({7'h00, gpa_di}, 8'h01);
        wrap_up();
    end
endmodule // twem_master_bench
`default_nettype wire
